// ==== rtl/cq_framer_cfg.svh ====
`ifndef CQ_FRAMER_CFG_SVH
`define CQ_FRAMER_CFG_SVH

// ****************************************************************
// descriptor geometry
// ****************************************************************
`define CQF_DESC_BYTES     16
`define CQF_DESC_W         128
`define CQF_HALF_W         64

// ****************************************************************
// common descriptor fields
// ****************************************************************
`define CQF_AT_HI          1
`define CQF_AT_LO          0
`define CQF_ADDR_HI        63
`define CQF_ADDR_LO        2
`define CQF_ADDR32_HI      31
`define CQF_DWC_HI         74
`define CQF_DWC_LO         64
`define CQF_TYPE_HI        78
`define CQF_TYPE_LO        75
`define CQF_RID_HI         95
`define CQF_RID_LO         80
`define CQF_TAG_HI         103
`define CQF_TAG_LO         96

// ****************************************************************
// message-specific fields in the low two dwords
// ****************************************************************
`define CQF_DEST_HI        15
`define CQF_DEST_LO        0
`define CQF_VEND_HI        31
`define CQF_VEND_LO        16
`define CQF_VHDR_HI        63
`define CQF_VHDR_LO        32
`define CQF_SNOOP_HI       15
`define CQF_SNOOP_LO       0
`define CQF_NOSNOOP_HI     31
`define CQF_NOSNOOP_LO     16
`define CQF_OBFF_HI        35
`define CQF_OBFF_LO        32
`define CQF_ATS_HI         63
`define CQF_ATS_LO         0

// ****************************************************************
// fixed values
// ****************************************************************
`define CQF_IO_DWC         11'h001
`define CQF_ZLEN_DWC       11'h001
`define CQF_BE_NONE        4'h0
`define CQF_FIFO_DEPTH     16
`define CQF_DATA_W         64

`endif

// ==== rtl/cq_framer_pkg.sv ====
package cq_framer_pkg;

`include "cq_framer_cfg.svh"

  // request kinds; K_MEM and K_ATOMIC share one descriptor layout, the others each have their own
  typedef enum logic [2:0] {
    K_MEM,
    K_IO,
    K_ATOMIC,
    K_VDM,
    K_ATS,
    K_MSG_OBFF,
    K_MSG_LTR,
    K_MSG_OTHER
  } req_kind_e;

  // header of one request as delivered by the transaction layer
  typedef struct packed {
    req_kind_e   kind;
    logic [1:0]  addr_type;
    logic        addr_is_64;
    logic [63:0] addr;
    logic        zero_length;
    logic [10:0] dword_count;
    logic [3:0]  req_type;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [7:0]  func;
    logic [7:0]  tag;
    logic [15:0] dest_id;
    logic [15:0] vendor_id;
    logic [31:0] vdm_bytes;
    logic [63:0] ats_body;
    logic [3:0]  obff_code;
    logic [15:0] snoop_lat;
    logic [15:0] nosnoop_lat;
    logic [3:0]  first_dword_byte_enables;
    logic [3:0]  last_dword_byte_enables;
    logic        has_payload;
  } req_s;

  // sideband that travels with every beat of a packet
  typedef struct packed {
    logic [3:0] first_dword_byte_enables;
    logic [3:0] last_dword_byte_enables;
    logic       sop;
  } sideband_s;

endpackage : cq_framer_pkg

// ==== rtl/stream_fifo.sv ====
`timescale 1ns/1ps

module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  wire              push;
  wire              load;

  assign in_ready  = (count_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign push      = in_valid & in_ready;
  assign load      = (count_r != '0) & (~out_valid_r | out_ready);
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(load);
  assign out_valid = out_valid_r;
  assign out_data  = out_data_r;

  // ****************************************************************
  // storage, no reset on the array
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // ****************************************************************
  // pointers and registered read stage
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_r    <= '0;
      rd_ptr_r    <= '0;
      count_r     <= '0;
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (ce) begin
      count_r <= count_nxt;
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (load) begin
        rd_ptr_r   <= rd_ptr_r + AW'(1);
        out_data_r <= mem_r[rd_ptr_r];
      end
      if (load) begin
        out_valid_r <= 1'b1;
      end else if (out_ready) begin
        out_valid_r <= 1'b0;
      end
    end
  end

endmodule : stream_fifo

// ==== rtl/completer_request_descriptor_framer.sv ====
`timescale 1ns/1ps

`include "cq_framer_cfg.svh"

module completer_request_descriptor_framer #(
  parameter int DATA_W     = `CQF_DATA_W,
  parameter int FIFO_DEPTH = `CQF_FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    ce,
  // configuration
  input  wire logic                    ari_enable,
  // request header from the transaction layer
  input  wire logic                    req_valid,
  output logic                         req_ready,
  input  wire cq_framer_pkg::req_s     req,
  // payload from the transaction layer, already lane aligned
  input  wire logic                    pay_valid,
  output logic                         pay_ready,
  input  wire logic [DATA_W-1:0]       pay_data,
  input  wire logic                    pay_last,
  // completer request stream
  output logic                         cq_tvalid,
  input  wire logic                    cq_tready,
  output logic [DATA_W-1:0]            cq_tdata,
  output logic                         cq_tlast,
  output cq_framer_pkg::sideband_s     completer_request_sideband
);

  import cq_framer_pkg::*;

  localparam int SB_W = $bits(sideband_s);
  localparam int FW   = DATA_W + 1 + SB_W;

  typedef enum logic [1:0] {
    S_IDLE,
    S_DESC,
    S_DESC_HI,
    S_PAY
  } state_e;

  // ****************************************************************
  // descriptor builder
  // ****************************************************************
  function automatic logic [`CQF_DESC_W-1:0] build_desc(input req_s r, input logic ari);
    logic [`CQF_DESC_W-1:0] d;
    logic [61:0]            dw_addr;
    d       = '0;
    dw_addr = r.addr_is_64 ? r.addr[`CQF_ADDR_HI:`CQF_ADDR_LO] :
                             {32'h0, r.addr[`CQF_ADDR32_HI:`CQF_ADDR_LO]};
    d[`CQF_TYPE_HI:`CQF_TYPE_LO] = r.req_type;
    d[`CQF_TAG_HI:`CQF_TAG_LO]   = r.tag;
    if (ari) begin
      d[`CQF_RID_HI:`CQF_RID_LO] = {r.bus, r.func};
    end else begin
      d[`CQF_RID_HI:`CQF_RID_LO] = {r.bus, r.dev, r.func[2:0]};
    end
    d[`CQF_DWC_HI:`CQF_DWC_LO] = r.dword_count;
    case (r.kind)
      K_MEM, K_ATOMIC: begin
        d[`CQF_AT_HI:`CQF_AT_LO]     = r.addr_type;
        d[`CQF_ADDR_HI:`CQF_ADDR_LO] = dw_addr;
        if (r.zero_length && r.kind == K_MEM) begin
          d[`CQF_DWC_HI:`CQF_DWC_LO] = `CQF_ZLEN_DWC;
        end
      end
      K_IO: begin
        d[`CQF_ADDR_HI:`CQF_ADDR_LO] = dw_addr;
        d[`CQF_DWC_HI:`CQF_DWC_LO]   = `CQF_IO_DWC;
      end
      K_VDM: begin
        d[`CQF_DEST_HI:`CQF_DEST_LO] = r.dest_id;
        d[`CQF_VEND_HI:`CQF_VEND_LO] = r.vendor_id;
        d[`CQF_VHDR_HI:`CQF_VHDR_LO] = r.vdm_bytes;
      end
      K_ATS: begin
        d[`CQF_ATS_HI:`CQF_ATS_LO] = r.ats_body;
      end
      K_MSG_OBFF: begin
        d[`CQF_OBFF_HI:`CQF_OBFF_LO] = r.obff_code;
      end
      K_MSG_LTR: begin
        d[`CQF_SNOOP_HI:`CQF_SNOOP_LO]     = r.snoop_lat;
        d[`CQF_NOSNOOP_HI:`CQF_NOSNOOP_LO] = r.nosnoop_lat;
      end
      default: begin
        // remaining messages keep their message-specific positions reserved
      end
    endcase
    return d;
  endfunction : build_desc

  // ****************************************************************
  // state
  // ****************************************************************
  state_e                 state_r;
  state_e                 state_nxt;
  logic [`CQF_DESC_W-1:0] desc_r;
  logic                   has_pay_r;
  sideband_s              sb_r;

  // ****************************************************************
  // fill side of the output buffer
  // ****************************************************************
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire [FW-1:0]           fifo_out_data;
  wire                    take_req;
  wire                    push_desc;
  wire                    push_hi;
  wire                    push_pay;
  wire                    push;
  wire                    desc_last;
  wire [DATA_W-1:0]       desc_beat;
  wire [DATA_W-1:0]       push_data;
  wire                    push_last;
  wire [FW-1:0]           push_word;
  wire                    zero_len_mem;
  sideband_s              sb_nxt;
  sideband_s              sb_push;

  assign take_req  = (state_r == S_IDLE) & req_valid;
  assign req_ready = (state_r == S_IDLE) ? 1'b1 : 1'b0;
  // payload waits for a fresh beat after the descriptor     
  assign pay_ready = (state_r == S_PAY) & fifo_in_ready;
  assign push_desc = (state_r == S_DESC) & fifo_in_ready;
  assign push_hi   = (state_r == S_DESC_HI) & fifo_in_ready;
  assign push_pay  = pay_ready & pay_valid;
  assign push      = push_desc | push_hi | push_pay;

  generate
    if (DATA_W == `CQF_HALF_W) begin : g_split
      // two beats carry the sixteen descriptor bytes
      assign desc_beat = push_hi ? desc_r[`CQF_DESC_W-1:`CQF_HALF_W] :
                                   desc_r[`CQF_HALF_W-1:0];
      assign desc_last = push_hi & ~has_pay_r;
    end else begin : g_whole
      // descriptor occupies the low sixteen bytes of the first beat
      assign desc_beat = {{(DATA_W-`CQF_DESC_W){1'b0}}, desc_r};
      assign desc_last = push_desc & ~has_pay_r;
    end
  endgenerate

  assign push_data = push_pay ? pay_data : desc_beat;
  assign push_last = push_pay ? pay_last : desc_last;

  assign zero_len_mem = (req.kind == K_MEM) & req.zero_length;
  assign sb_nxt.first_dword_byte_enables = zero_len_mem ? `CQF_BE_NONE :
                                           req.first_dword_byte_enables;
  assign sb_nxt.last_dword_byte_enables  = req.last_dword_byte_enables;
  assign sb_nxt.sop                      = 1'b1;

  assign sb_push.first_dword_byte_enables = sb_r.first_dword_byte_enables;
  assign sb_push.last_dword_byte_enables  = sb_r.last_dword_byte_enables;
  assign sb_push.sop                      = push_desc;
  assign push_word = {push_data, push_last, sb_push};

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (take_req) begin
          state_nxt = S_DESC;
        end
      end
      S_DESC: begin
        if (push_desc) begin
          if (DATA_W == `CQF_HALF_W) begin
            state_nxt = S_DESC_HI;
          end else if (has_pay_r) begin
            state_nxt = S_PAY;
          end else begin
            state_nxt = S_IDLE;
          end
        end
      end
      S_DESC_HI: begin
        if (push_hi) begin
          state_nxt = has_pay_r ? S_PAY : S_IDLE;
        end
      end
      S_PAY: begin
        if (push_pay && pay_last) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r   <= S_IDLE;
      desc_r    <= '0;
      has_pay_r <= 1'b0;
      sb_r      <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (take_req) begin
        desc_r    <= build_desc(req, ari_enable);
        has_pay_r <= req.has_payload;
        sb_r      <= sb_nxt;
      end
    end
  end

  // ****************************************************************
  // output buffer; its fill ready stalls the sequencer
  // ****************************************************************
  stream_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (cq_tready),
    .out_data  (fifo_out_data)
  );

  assign cq_tvalid                  = fifo_out_valid;
  assign cq_tdata                   = fifo_out_data[FW-1 -: DATA_W];
  assign cq_tlast                   = fifo_out_data[SB_W];
  assign completer_request_sideband = fifo_out_data[SB_W-1:0];

endmodule : completer_request_descriptor_framer

// ==== dv/cq_framer_properties.sv ====
`timescale 1ns/1ps

module cq_framer_checker
  import cq_framer_pkg::*;
#(
  parameter int DATA_W     = 64,
  parameter int FIFO_DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              ari_enable,
  // request and payload side
  input  wire logic              req_valid,
  input  wire logic              req_ready,
  input  wire req_s              req,
  input  wire logic              pay_valid,
  input  wire logic              pay_ready,
  input  wire logic [DATA_W-1:0] pay_data,
  input  wire logic              pay_last,
  // completer request stream
  input  wire logic              cq_tvalid,
  input  wire logic              cq_tready,
  input  wire logic [DATA_W-1:0] cq_tdata,
  input  wire logic              cq_tlast,
  input  wire sideband_s         completer_request_sideband
);
  // ****************************************
  // beat position within the current packet
  // ****************************************
  logic [1:0] bcnt_r;
  logic [3:0] be_r;
  wire logic  beat_w = cq_tvalid && cq_tready && ce;
  wire logic  sop_w  = completer_request_sideband.sop;
  wire logic [3:0] fbe_w = completer_request_sideband.first_dword_byte_enables;

  // the count saturates: only the two descriptor beats need telling apart
  always_ff @(posedge core_clk) begin
    if (rst) bcnt_r <= 2'h0;
    else if (beat_w) bcnt_r <= cq_tlast ? 2'h0 : (bcnt_r == 2'h3 ? 2'h3 : bcnt_r + 2'h1);
  end
  always_ff @(posedge core_clk) begin
    if (beat_w && sop_w) be_r <= fbe_w;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_take;
    req_valid && req_ready && ce;
  endsequence
  sequence s_first_out;
    cq_tvalid && sop_w && !cq_tlast;
  endsequence

  property p_take_to_sop;
    s_take |-> ##[2:1000] s_first_out;
  endproperty
  property p_one_at_a_time;
    s_take |=> !req_ready [*2];
  endproperty
  property p_hold;
    cq_tvalid && !cq_tready |=> cq_tvalid && $stable(cq_tdata) && $stable(cq_tlast)
      && $stable(completer_request_sideband);
  endproperty
  property p_sop_first;
    cq_tvalid |-> sop_w == (bcnt_r == 2'h0);
  endproperty
  property p_desc_two_beats;
    cq_tvalid && bcnt_r == 2'h0 |-> !cq_tlast;
  endproperty
  property p_upper_zero;
    cq_tvalid && bcnt_r == 2'h1 |-> cq_tdata[15] == 1'b0 && cq_tdata[63:40] == 24'h0;
  endproperty
  property p_dwc_range;
    cq_tvalid && bcnt_r == 2'h1 |-> cq_tdata[10:0] <= 11'h100;
  endproperty
  property p_be_steady;
    cq_tvalid && bcnt_r != 2'h0 |-> fbe_w == be_r;
  endproperty
  property p_pay_gate;
    pay_ready |-> !req_ready;
  endproperty
  property p_zero_len;
    req_valid && req_ready && ce && req.kind == K_MEM && req.zero_length
      |-> ##[2:1000] cq_tvalid && sop_w && fbe_w == 4'h0;
  endproperty

  a_take_to_sop: assert property (p_take_to_sop) else $error("no descriptor after request taken");
  a_one_at_a_time: assert property (p_one_at_a_time) else $error("request taken mid packet");
  a_hold: assert property (p_hold) else $error("stream beat changed while stalled");
  a_sop_first: assert property (p_sop_first) else $error("start flag on wrong beat");
  a_desc_two_beats: assert property (p_desc_two_beats) else $error("packet ended in first beat");
  a_upper_zero: assert property (p_upper_zero) else $error("undefined descriptor bits set");
  a_dwc_range: assert property (p_dwc_range) else $error("dword count above 256");
  a_be_steady: assert property (p_be_steady) else $error("byte enables changed in packet");
  a_pay_gate: assert property (p_pay_gate) else $error("payload accepted while idle");
  a_zero_len: assert property (p_zero_len) else $error("zero length enables not cleared");
endmodule : cq_framer_checker

bind completer_request_descriptor_framer cq_framer_checker #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH))
  cq_framer_checker_i (.core_clk(core_clk), .rst(rst), .ce(ce), .ari_enable(ari_enable),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .pay_valid(pay_valid), .pay_ready(pay_ready),
  .pay_data(pay_data), .pay_last(pay_last), .cq_tvalid(cq_tvalid), .cq_tready(cq_tready),
  .cq_tdata(cq_tdata), .cq_tlast(cq_tlast), .completer_request_sideband(completer_request_sideband));

// ==== dv/cq_sink_model.sv ====
`timescale 1ns/1ps

module cq_sink_model (
  // clock and control
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [1:0]  stall_mode,
  // completer request stream
  input  wire logic        cq_tvalid,
  output logic             cq_tready,
  input  wire logic [63:0] cq_tdata,
  input  wire logic        cq_tlast,
  // identity kept for the completion
  output logic [15:0]      kept_id,
  output logic [7:0]       kept_tag
);
  logic [15:0] lf_r;
  logic [1:0]  beat_r;

  // mode 0 prompt, mode 1 uneven drain, mode 2 stalled so the fifo fills
  assign cq_tready = (stall_mode == 2'h0) || (stall_mode == 2'h1 && lf_r[1:0] == 2'h0);

  always_ff @(posedge core_clk) begin
    lf_r <= rst ? 16'hace1 : {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
    if (rst) begin
      beat_r <= 2'h0;
    end else if (cq_tvalid && cq_tready && ce) begin
      beat_r <= cq_tlast ? 2'h0 : (beat_r == 2'h2 ? 2'h2 : beat_r + 2'h1);
      if (beat_r == 2'h1) begin
        kept_id  <= cq_tdata[31:16];
        kept_tag <= cq_tdata[39:32];
      end
    end
  end
endmodule : cq_sink_model

// ==== dv/completer_request_descriptor_framer_tb.sv ====
`timescale 1ns/1ps

module completer_request_descriptor_framer_tb;
  import cq_framer_pkg::*;
  logic         core_clk, rst, ari_enable, req_valid, pay_valid, pay_last, ce_on;
  logic         ce = 1'b1;
  logic         req_ready, pay_ready, cq_tvalid, cq_tready, cq_tlast;
  logic [63:0]  pay_data, cq_tdata;
  req_s         req;
  sideband_s    sb;
  logic [1:0]   stall_mode;
  logic [15:0]  kept_id;
  logic [7:0]   kept_tag;
  logic [7:0]   ce_lf = 8'h5a;
  logic [31:0]  seed = 32'h99dd;
  logic [73:0]  exp_q[$];
  logic [127:0] last_desc;
  int           miscompares, n_checks;

  completer_request_descriptor_framer #(.DATA_W(64), .FIFO_DEPTH(16)) completer_request_descriptor_framer_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .ari_enable(ari_enable), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data),
    .pay_last(pay_last), .cq_tvalid(cq_tvalid), .cq_tready(cq_tready), .cq_tdata(cq_tdata),
    .cq_tlast(cq_tlast), .completer_request_sideband(sb));
  cq_sink_model cq_sink_model_i (.core_clk(core_clk), .rst(rst), .ce(ce), .stall_mode(stall_mode),
    .cq_tvalid(cq_tvalid), .cq_tready(cq_tready), .cq_tdata(cq_tdata), .cq_tlast(cq_tlast),
    .kept_id(kept_id), .kept_tag(kept_tag));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction : rnd

  function automatic logic [127:0] exp_desc(input req_s r, input logic ari);
    logic [127:0] d;
    d = 128'h0;
    if (r.kind inside {K_MEM, K_IO, K_ATOMIC}) d[63:2] = r.addr_is_64 ? r.addr[63:2] : {32'h0, r.addr[31:2]};
    if (r.kind inside {K_MEM, K_ATOMIC}) d[1:0] = r.addr_type;
    if (r.kind == K_VDM) d[63:0] = {r.vdm_bytes, r.vendor_id, r.dest_id};
    if (r.kind == K_ATS) d[63:0] = r.ats_body;
    if (r.kind == K_MSG_OBFF) d[35:32] = r.obff_code;
    if (r.kind == K_MSG_LTR) d[31:0] = {r.nosnoop_lat, r.snoop_lat};
    d[74:64] = (r.kind == K_IO || (r.kind == K_MEM && r.zero_length)) ? 11'h001 : r.dword_count;
    d[78:75] = r.req_type;
    d[95:80] = ari ? {r.bus, r.func} : {r.bus, r.dev, r.func[2:0]};
    d[103:96] = r.tag;
    return d;
  endfunction : exp_desc

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // waits for the edge that accepts the held request or payload beat
  task automatic hs(input logic pay);
    int t;
    for (t = 0; t < 2000; t++) begin
      @(posedge core_clk);
      if (ce && (pay ? pay_ready : req_ready)) return;
    end
    check(128'h1, 128'h0, "handshake timeout");
  endtask : hs

  task automatic send(input req_s r, input int nbeats, input logic a);
    logic [3:0]  fbe;
    logic [63:0] d;
    int          k;
    @(posedge core_clk);
    r.has_payload = (nbeats != 0);
    fbe = (r.kind == K_MEM && r.zero_length) ? 4'h0 : r.first_dword_byte_enables;
    last_desc = exp_desc(r, a);
    exp_q.push_back({1'b0, 1'b1, fbe, r.last_dword_byte_enables, last_desc[63:0]});
    exp_q.push_back({nbeats == 0, 1'b0, fbe, r.last_dword_byte_enables, last_desc[127:64]});
    req_valid  <= 1'b1;
    req        <= r;
    ari_enable <= a;
    hs(1'b0);
    req_valid <= 1'b0;
    for (k = 1; k <= nbeats; k++) begin
      d = {rnd(), rnd()};
      exp_q.push_back({k == nbeats, 1'b0, fbe, r.last_dword_byte_enables, d});
      pay_valid <= 1'b1;
      pay_data  <= d;
      pay_last  <= (k == nbeats);
      hs(1'b1);
    end
    pay_valid <= 1'b0;
  endtask : send

  task automatic drain();
    int t;
    for (t = 0; t < 3000 && exp_q.size() != 0; t++) @(posedge core_clk);
    check(128'(exp_q.size()), 128'h0, "beats missing");
  endtask : drain

  // ****************************************
  // clock, enable, monitor, watchdog
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    ce_lf <= {ce_lf[6:0], ce_lf[7] ^ ce_lf[5] ^ ce_lf[4] ^ ce_lf[3]};
    ce    <= !(ce_on && ce_lf[2:0] == 3'h0);
    if (!rst && ce && cq_tvalid && cq_tready) begin
      if (exp_q.size() == 0) check(128'h1, 128'h0, "unexpected beat");
      else check({cq_tlast, sb.sop, sb.first_dword_byte_enables, sb.last_dword_byte_enables, cq_tdata},
                 exp_q.pop_front(), "stream beat");
    end
  end

  // 89 packets of a few dozen cycles each; this leaves wide margin
  initial begin
    repeat (50000) @(posedge core_clk);
    miscompares++;
    report_and_stop();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    req_s r;
    int   i;
    {rst, ari_enable, req_valid, pay_valid, pay_last, ce_on} = 6'b100000;
    {req, pay_data, stall_mode} = '0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 88; i++) begin
      if (i == 48) begin
        ce_on      <= 1'b1;
        stall_mode <= 2'h1;
      end
      r = req_s'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
      r.kind        = i < 48 ? req_kind_e'(i % 8) : req_kind_e'(rnd() % 8);
      r.dword_count = 11'(rnd() % 257);
      if (i < 8) {r.zero_length, r.dword_count} = {1'b1, 11'h100};
      else if (i < 16) {r.zero_length, r.addr_is_64, r.dword_count} = 13'h0;
      send(r, int'(rnd() % 4), seed[7]);
      if (i == 47) $display("kind sweep done");
    end
    drain();
    $display("random traffic with stalls done");
    ce_on      <= 1'b0;
    stall_mode <= 2'h2;
    r = req_s'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
    r.kind = K_MEM;
    fork
      send(r, 20, 1'b1);
      begin
        repeat (80) @(posedge core_clk);
        @(negedge core_clk);
        check(128'(pay_ready), 128'h0, "full fifo still accepts");
        @(posedge core_clk);
        stall_mode <= 2'h0;
      end
    join
    drain();
    check(128'(kept_id), 128'(last_desc[95:80]), "kept identifier");
    check(128'(kept_tag), 128'(last_desc[103:96]), "kept tag");
    $display("fill and drain done");
    report_and_stop();
  end
endmodule : completer_request_descriptor_framer_tb
